// ---- logic/sdram_timing_pkg.sv ----
// package: sdram timing control register map, fields and timing codes
package sdram_timing_pkg;
    // register word offsets (byte addresses)
    localparam logic [3:0]  TIMING_CTRL_OFS   = 4'h0;
    localparam logic [3:0]  LATENCY_CTRL_OFS  = 4'h4;
    localparam logic [3:0]  SEQ_CTRL_OFS      = 4'h8;
    localparam logic [3:0]  STATUS_OFS        = 4'hc;
    // field positions in the timing control register
    localparam int PRECHARGE_POS   = 14;
    localparam int ACT_DELAY_POS   = 12;
    localparam int WR_RECOVERY_POS = 10;
    localparam int RF_HOLD_POS     = 8;
    localparam int BANK_MODE_POS   = 7;
    localparam int ADDR_MUX_POS    = 3;
    localparam int RF_ENABLE_POS   = 2;
    localparam int RF_KIND_POS     = 1;
    // reset values and timing write mask
    localparam logic [15:0] TIMING_CTRL_RST  = 16'h0000;
    localparam logic [1:0]  LATENCY_RST      = 2'h3;
    localparam logic [15:0] TIMING_WMASK     = 16'hfffe;
    // address multiplex codes and their row start bits
    localparam logic [3:0]  AMX_A10_WIDE = 4'hd;
    localparam logic [3:0]  AMX_A11      = 4'he;
    localparam logic [3:0]  AMX_A9       = 4'h4;
    localparam logic [3:0]  AMX_A10      = 4'h5;
    localparam logic [3:0]  AMX_A9_32    = 4'h7;
    localparam logic [3:0]  ROW_A9       = 4'h9;
    localparam logic [3:0]  ROW_A10      = 4'ha;
    localparam logic [3:0]  ROW_A11      = 4'hb;
    // gap offsets and self-refresh step in cycles
    localparam logic [3:0]  SELF_RF_STEP  = 4'h3;
    localparam logic [3:0]  SELF_RF_BASE  = 4'h2;
    localparam logic [3:0]  RF_HOLD_BASE  = 4'h2;
    // sequence commands
    localparam logic [2:0]  CMD_PRE_ALL   = 3'h1;
    localparam logic [2:0]  CMD_PRE_BANK  = 3'h2;
    localparam logic [2:0]  CMD_WRITE_END = 3'h3;
    localparam logic [2:0]  CMD_AUTO_RF   = 3'h4;
    localparam logic [2:0]  CMD_SELF_EXIT = 3'h5;
    localparam logic [2:0]  CMD_ACTIVATE  = 3'h6;
endpackage : sdram_timing_pkg

// ---- logic/sdram_timing_control.sv ----
// sdram timing control register and sequencing gap logic
`timescale 1ns/1ps
module sdram_timing_control (
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        power_on_rst,
    input  wire logic        ce,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // memory side events
    input  wire logic        bus_cycle_busy,
    input  wire logic        refresh_req,
    input  wire logic        self_refresh_exit,
    input  wire logic        seq_cmd_valid,
    input  wire logic [2:0]  seq_cmd,
    // timing outputs
    output logic      [1:0]  cas_latency,
    output logic      [2:0]  act_to_access_cycles,
    output logic             bank_keep_open_mode,
    output logic      [3:0]  row_start_bit,
    output logic             addr_mux_valid,
    output logic             activate_allowed,
    output logic             auto_refresh_go,
    output logic             self_refresh_go
);

    logic [1:0]  rst_sync_r;
    logic        rstn;
    logic [15:0] timing_r;
    logic [1:0]  latency_r;
    logic [3:0]  gap_r;
    logic        in_self_r;
    logic        rf_pend_r;
    logic        ack_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rstn = rst_sync_r[1];

    localparam int PRE_LO  = sdram_timing_pkg::PRECHARGE_POS;
    localparam int PRE_HI  = PRE_LO + 1;
    localparam int ACT_LO  = sdram_timing_pkg::ACT_DELAY_POS;
    localparam int ACT_HI  = ACT_LO + 1;
    localparam int WR_LO   = sdram_timing_pkg::WR_RECOVERY_POS;
    localparam int WR_HI   = WR_LO + 1;
    localparam int HOLD_LO = sdram_timing_pkg::RF_HOLD_POS;
    localparam int HOLD_HI = HOLD_LO + 1;
    localparam int AMX_LO  = sdram_timing_pkg::ADDR_MUX_POS;
    localparam int AMX_HI  = AMX_LO + 3;

    // field decode
    wire [1:0] precharge_code = timing_r[PRE_HI:PRE_LO];
    wire [1:0] act_code       = timing_r[ACT_HI:ACT_LO];
    wire [1:0] wr_code        = timing_r[WR_HI:WR_LO];
    wire [1:0] hold_code      = timing_r[HOLD_HI:HOLD_LO];
    wire [3:0] amx_code       = timing_r[AMX_HI:AMX_LO];
    wire       rf_enable      = timing_r[sdram_timing_pkg::RF_ENABLE_POS];
    wire       rf_kind        = timing_r[sdram_timing_pkg::RF_KIND_POS];
    wire       bank_mode      = timing_r[sdram_timing_pkg::BANK_MODE_POS];

    // code plus one cycle count
    function automatic logic [3:0] code_cycles(input logic [1:0] code);
        code_cycles = {2'h0, code} + 4'h1;
    endfunction : code_cycles

    wire [3:0] pre_gap = code_cycles(precharge_code);
    wire [3:0] self_gap = sdram_timing_pkg::SELF_RF_BASE
                        + 4'({2'h0, precharge_code}
                        * sdram_timing_pkg::SELF_RF_STEP);

    wire [1:0] cas_nxt = (latency_r == 2'h0) ? 2'h1 : latency_r;

    logic [3:0] row_nxt;
    logic       mux_ok_nxt;
    always_comb begin
        row_nxt    = 4'h0;
        mux_ok_nxt = 1'b1;
        unique case (amx_code)
            sdram_timing_pkg::AMX_A10_WIDE: row_nxt = sdram_timing_pkg::ROW_A10;
            sdram_timing_pkg::AMX_A11:      row_nxt = sdram_timing_pkg::ROW_A11;
            sdram_timing_pkg::AMX_A9:       row_nxt = sdram_timing_pkg::ROW_A9;
            sdram_timing_pkg::AMX_A10:      row_nxt = sdram_timing_pkg::ROW_A10;
            sdram_timing_pkg::AMX_A9_32:    row_nxt = sdram_timing_pkg::ROW_A9;
            default:                        mux_ok_nxt = 1'b0;
        endcase
    end

    // gap load for each sequence event
    logic [3:0] gap_load;
    always_comb begin
        gap_load = 4'h0;
        case (seq_cmd)
            sdram_timing_pkg::CMD_PRE_ALL:  gap_load = pre_gap - 4'h1;
            sdram_timing_pkg::CMD_PRE_BANK:
                gap_load = bank_mode ? pre_gap - 4'h1 : pre_gap;
            sdram_timing_pkg::CMD_WRITE_END:
                gap_load = pre_gap + code_cycles(wr_code);
            sdram_timing_pkg::CMD_AUTO_RF:
                gap_load = pre_gap + {2'h0, hold_code}
                         + sdram_timing_pkg::RF_HOLD_BASE;
            sdram_timing_pkg::CMD_SELF_EXIT: gap_load = self_gap;
            default: gap_load = 4'h0;
        endcase
    end

    // wishbone decode
    wire        wb_req  = wb_cyc_i & wb_stb_i & ~ack_r;
    wire        wb_wr   = wb_req & wb_we_i;
    wire        hit_tim = wb_adr_i == sdram_timing_pkg::TIMING_CTRL_OFS;
    wire        hit_lat = wb_adr_i == sdram_timing_pkg::LATENCY_CTRL_OFS;
    wire        hit_st  = wb_adr_i == sdram_timing_pkg::STATUS_OFS;
    wire [15:0] bmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}
                        & sdram_timing_pkg::TIMING_WMASK;
    wire [15:0] tim_nxt = (timing_r & ~bmask) | (wb_dat_i[15:0] & bmask);
    wire [31:0] rd_val  = hit_tim ? {16'h0, timing_r}
                        : hit_lat ? {27'h0, latency_r, 3'h0}
                        : hit_st  ? {28'h0, rf_pend_r, in_self_r,
                                     mux_ok_nxt, gap_r == 4'h0}
                        : 32'h0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            timing_r  <= sdram_timing_pkg::TIMING_CTRL_RST;
            latency_r <= sdram_timing_pkg::LATENCY_RST;
        end else if (ce) begin
            if (power_on_rst) begin
                timing_r  <= sdram_timing_pkg::TIMING_CTRL_RST;
                latency_r <= sdram_timing_pkg::LATENCY_RST;
            end else if (wb_wr && hit_tim) begin
                timing_r <= tim_nxt;
            end else if (wb_wr && hit_lat && wb_sel_i[0]) begin
                latency_r <= wb_dat_i[4:3];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
        end else if (ce) begin
            ack_r <= wb_req;
        end
    end

    // refresh and gap sequencing
    wire rf_run   = rf_enable & ~rf_kind;
    wire gap_done = gap_r == 4'h0;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap_r     <= 4'h0;
            in_self_r <= 1'b0;
            rf_pend_r <= 1'b0;
        end else if (ce) begin
            if (seq_cmd_valid && seq_cmd != sdram_timing_pkg::CMD_ACTIVATE)
                gap_r <= gap_load;
            else if (!gap_done)
                gap_r <= gap_r - 4'h1;
            if (self_refresh_exit)
                in_self_r <= 1'b0;
            else if (rf_enable && rf_kind && !bus_cycle_busy)
                in_self_r <= 1'b1;
            if (rf_run && !bus_cycle_busy)
                rf_pend_r <= 1'b0;
            else if (refresh_req && rf_run && !in_self_r)
                rf_pend_r <= 1'b1;
            else if (!rf_run)
                rf_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cas_latency          <= sdram_timing_pkg::LATENCY_RST;
            act_to_access_cycles <= 3'h1;
            bank_keep_open_mode  <= 1'b0;
            row_start_bit        <= 4'h0;
            addr_mux_valid       <= 1'b0;
            activate_allowed     <= 1'b1;
            auto_refresh_go      <= 1'b0;
            self_refresh_go      <= 1'b0;
            wb_ack_o             <= 1'b0;
            wb_dat_o             <= 32'h0;
        end else if (ce) begin
            cas_latency          <= cas_nxt;
            act_to_access_cycles <= 3'(code_cycles(act_code));
            bank_keep_open_mode  <= bank_mode;
            row_start_bit        <= row_nxt;
            addr_mux_valid       <= mux_ok_nxt;
            activate_allowed     <= gap_done && !in_self_r;
            auto_refresh_go      <= rf_run && !bus_cycle_busy && !in_self_r
                                    && (rf_pend_r || refresh_req);
            self_refresh_go      <= in_self_r;
            wb_ack_o             <= wb_req;
            wb_dat_o             <= rd_val;
        end
    end

    a_gap_counts: assert property (@(posedge clk) disable iff (!rstn)
        ce && seq_cmd_valid && seq_cmd == sdram_timing_pkg::CMD_PRE_ALL
        |=> gap_r == pre_gap - 4'h1)
        else $error("precharge gap wrong");
    a_bit0_zero: assert property (@(posedge clk) disable iff (!rstn)
        timing_r[0] == 1'b0)
        else $error("bit 0 set");
    a_refresh_off: assert property (@(posedge clk) disable iff (!rstn)
        ce && !rf_enable |=> !auto_refresh_go)
        else $error("refresh while disabled");
    a_rf_defer: assert property (@(posedge clk) disable iff (!rstn)
        ce && bus_cycle_busy |=> !auto_refresh_go)
        else $error("refresh during bus cycle");
    a_cas_map: assert property (@(posedge clk) disable iff (!rstn)
        ce ##1 ce |-> cas_latency == (($past(latency_r) == 2'h0)
        ? 2'h1 : $past(latency_r)))
        else $error("latency map wrong");
    a_write_gap: assert property (@(posedge clk) disable iff (!rstn)
        ce && seq_cmd_valid && seq_cmd == sdram_timing_pkg::CMD_WRITE_END
        |=> gap_r == pre_gap + code_cycles(wr_code))
        else $error("write gap wrong");
    a_rf_gap: assert property (@(posedge clk) disable iff (!rstn)
        ce && seq_cmd_valid && seq_cmd == sdram_timing_pkg::CMD_AUTO_RF
        |=> gap_r == pre_gap + {2'h0, hold_code}
            + sdram_timing_pkg::RF_HOLD_BASE)
        else $error("refresh gap wrong");
    a_act_delay: assert property (@(posedge clk) disable iff (!rstn)
        ce ##1 ce |-> act_to_access_cycles ==
        3'({1'b0, $past(act_code)} + 3'h1))
        else $error("access delay wrong");
    // self-refresh request and its two steps
    sequence s_self_ask;
        ce && rf_enable && rf_kind && !bus_cycle_busy && !self_refresh_exit;
    endsequence
    sequence s_self_held;
        in_self_r ##1 self_refresh_go;
    endsequence
    a_self_entry: assert property (@(posedge clk) disable iff (!rstn)
        s_self_ask ##1 ce |-> s_self_held)
        else $error("self-refresh not entered");
    a_self_quiet: assert property (@(posedge clk) disable iff (!rstn)
        ce && in_self_r |=> !auto_refresh_go)
        else $error("refresh during self-refresh");
    a_bank_pre: assert property (@(posedge clk) disable iff (!rstn)
        ce && seq_cmd_valid && seq_cmd == sdram_timing_pkg::CMD_PRE_BANK
        |=> gap_r == (bank_mode ? pre_gap - 4'h1 : pre_gap))
        else $error("bank precharge gap wrong");
    a_row_map: assert property (@(posedge clk) disable iff (!rstn)
        ce && amx_code == sdram_timing_pkg::AMX_A9
        |=> addr_mux_valid && row_start_bit == sdram_timing_pkg::ROW_A9)
        else $error("row start wrong");

endmodule : sdram_timing_control

// ---- sim/sdram_model.sv ----
// external sdram stand-in: counts refresh commands, follows self-refresh
`timescale 1ns/1ps
module sdram_model (
    // clock
    input  wire logic clk,
    // commands from the controller
    input  wire logic auto_rf,
    input  wire logic self_rf,
    // observed state
    output int        rf_count,
    output logic      in_self
);
    int count_r = 0;
    assign rf_count = count_r;
    assign in_self  = self_rf;
    always @(posedge clk) begin
        if (auto_rf === 1'b1) begin
            count_r <= count_r + 1;
        end
    end
endmodule : sdram_model

// ---- sim/testbench.sv ----
// self-checking bench for the sdram timing control block
`timescale 1ns/1ps
module testbench;
    logic        clk, nrst, por, busy, rf_req, sx, cv;
    logic        cyc, stb, we, ack, keep, mvalid, allow, ago, sgo, in_self;
    logic [2:0]  cmd, act;
    logic [3:0]  adr, row, sel;
    logic [31:0] wdat, rdat, d;
    logic [1:0]  cas;
    logic [15:0] r;
    logic [4:0]  e;
    int          bad_count, n_compared, n, nb, na, rfc;

    sdram_timing_control dut (.clk(clk), .nrst(nrst), .power_on_rst(por),
        .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .bus_cycle_busy(busy), .refresh_req(rf_req),
        .self_refresh_exit(sx), .seq_cmd_valid(cv), .seq_cmd(cmd),
        .cas_latency(cas), .act_to_access_cycles(act),
        .bank_keep_open_mode(keep), .row_start_bit(row),
        .addr_mux_valid(mvalid), .activate_allowed(allow),
        .auto_refresh_go(ago), .self_refresh_go(sgo));
    sdram_model mem (.clk(clk), .auto_rf(ago), .self_rf(sgo),
        .rf_count(rfc), .in_self(in_self));

    task automatic chk(input string nm, input logic [31:0] x, g);
        n_compared++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] v, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 50) chk("ack", 1, 0);
    endtask : wb

    // low cycles of activate_allowed after one sequence command
    task automatic gm(input logic [2:0] c, output int k);
        k = 0;
        @(posedge clk);
        cv <= 1'b1;
        cmd <= c;
        @(posedge clk);
        cv <= 1'b0;
        repeat (20) begin
            @(posedge clk);
            if (allow !== 1'b1) k++;
        end
    endtask : gm

    task automatic rf_try(input int hold, output int b, output int a);
        b = 0;
        a = 0;
        @(posedge clk);
        busy <= (hold > 0);
        rf_req <= 1'b1;
        @(posedge clk);
        rf_req <= 1'b0;
        repeat (hold) begin
            @(posedge clk);
            if (ago === 1'b1) b++;
        end
        busy <= 1'b0;
        repeat (10) begin
            @(posedge clk);
            if (ago === 1'b1) a++;
        end
    endtask : rf_try

    function automatic int gap(input logic [2:0] c, input logic [15:0] v);
        int p;
        p = v[15:14] + 1;
        case (c)
            3'h1: return p - 1;
            3'h2: return v[7] ? p - 1 : p;
            3'h3: return p + v[11:10] + 1;
            3'h4: return p + v[9:8] + 2;
            default: return 3 * v[15:14] + 2;
        endcase
    endfunction : gap

    function automatic logic [4:0] mux_exp(input logic [3:0] a);
        case (a)
            4'hd, 4'h5: return 5'h1a;
            4'he: return 5'h1b;
            4'h4, 4'h7: return 5'h19;
            default: return 5'h00;
        endcase
    endfunction : mux_exp

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #(8 * 20000);
        bad_count++;
        finish_test();
    end

    initial begin
        {nrst, busy, rf_req, sx, cv, cyc, stb, we} = 8'h00;
        por = 1'b1;
        cmd = 3'h0;
        adr = 4'h0;
        sel = 4'hf;
        wdat = 32'h0;
        bad_count = 0;
        n_compared = 0;
        void'($urandom(95));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        por <= 1'b0;
        repeat (3) @(posedge clk);
        wb(0, 4'h0, 0, d);
        chk("timing reset", 0, d);
        wb(0, 4'h4, 0, d);
        chk("latency reset", 32'h18, d);
        chk("cas reset", 3, cas);
        chk("mux reset", 0, mvalid);
        wb(1, 4'h2, 32'hffff, d);
        wb(0, 4'h2, 0, d);
        chk("unmapped", 0, d);
        wb(0, 4'hc, 0, d);
        chk("status reset", 32'h1, d);
        gm(3'h2, n);
        chk("gap reset", 1, n);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            wb(1, 4'h4, i << 3, d);
            wb(0, 4'h4, 0, d);
            chk("latency rd", i << 3, d);
            chk("cas", (i < 2) ? 1 : i, cas);
        end
        $display("latency test done");
        for (int i = 0; i < 16; i++) begin
            r = 16'($urandom());
            r[6:3] = 4'(i);
            r[2:0] = 3'h1;
            if (r[11:10] == 2'h3) r[11:10] = 2'h2;
            if (r[7] && r[15:14] == 2'h1) r[15:14] = 2'h0;
            wb(1, 4'h0, {16'h0, r}, d);
            wb(0, 4'h0, 0, d);
            chk("timing rd", {16'h0, r & 16'hfffe}, d);
            chk("act delay", r[13:12] + 1, act);
            chk("bank mode", r[7], keep);
            e = mux_exp(r[6:3]);
            chk("mux valid", e[4], mvalid);
            if (e[4]) chk("row start", e[3:0], row);
            for (int c = 1; c < 6; c++) begin
                gm(3'(c), n);
                chk("gap", gap(3'(c), r), n);
            end
        end
        $display("field test done");
        @(posedge clk);
        por <= 1'b1;
        repeat (2) @(posedge clk);
        por <= 1'b0;
        wb(0, 4'h0, 0, d);
        chk("power-on clear", 0, d);
        sel <= 4'h2;
        wb(1, 4'h0, 32'h55ff, d);
        sel <= 4'hf;
        wb(0, 4'h0, 0, d);
        chk("byte lane", 32'h5500, d);
        $display("power-on test done");
        wb(1, 4'h0, 32'h4, d);
        rf_try(0, nb, na);
        chk("auto refresh", 1, na);
        rf_try(6, nb, na);
        chk("refresh in bus", 0, nb);
        chk("refresh after", 1, na);
        wb(1, 4'h0, 32'h0, d);
        rf_try(0, nb, na);
        chk("refresh off", 0, na);
        chk("model count", 2, rfc);
        busy <= 1'b1;
        wb(1, 4'h0, 32'h6, d);
        repeat (5) @(posedge clk);
        chk("self in bus", 0, sgo);
        busy <= 1'b0;
        n = 0;
        repeat (10) begin
            @(posedge clk);
            if (sgo === 1'b1) n++;
        end
        chk("self entered", 1, n > 0);
        chk("model self", 1, in_self);
        // back to auto mode while still in self-refresh
        wb(1, 4'h0, 32'h4, d);
        rf_try(0, nb, na);
        chk("refresh in self", 0, na);
        sx <= 1'b1;
        @(posedge clk);
        sx <= 1'b0;
        rf_try(0, nb, na);
        chk("refresh after exit", 1, na);
        wb(1, 4'h0, 32'h0, d);
        $display("refresh test done");
        finish_test();
    end
endmodule : testbench
